// >>> pkg/flash_guard_regs.svh
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// ----------------------------------------------------------------
// address widths and layout
// ----------------------------------------------------------------
`define FG_ADDR_W        13
`define FG_PAGE_MSB      12
`define FG_PAGE_LSB      5
`define FG_PAGE_W        8
`define FG_HALT_BASE     13'h1c00
// boot section start per boot size fuse code (3=smallest)
`define FG_BOOT_BASE_0   13'h1c00
`define FG_BOOT_BASE_1   13'h1e00
`define FG_BOOT_BASE_2   13'h1f00
`define FG_BOOT_BASE_3   13'h1f80
// control patterns, low five bits
`define FG_CMD_MASK      8'h1f
`define FG_CMD_ERASE     8'h03
`define FG_CMD_WRITE     8'h05
`define FG_CMD_REEN      8'h11
// arm window and programming time
`define FG_ARM_CYCLES    3'h4
`define FG_PROG_T_US     32'd4000
`define FG_CLK_MHZ       32'd50
`define FG_PROG_CYCLES   (`FG_PROG_T_US * `FG_CLK_MHZ)
`define FG_CNT_W         18

`endif

// >>> pkg/flash_guard_pkg.sv
package flash_guard_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_PROG  = 2'b10
   } guard_state_e;

   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_ERASE = 2'b01,
      OP_WRITE = 2'b10
   } prog_op_e;

   // lock pairs, 1 = unprogrammed
   typedef struct packed {
      logic boot_read_lock_bit;
      logic boot_write_lock_bit;
      logic application_read_lock_bit;
      logic application_write_lock_bit;
   } lock_bits_s;

   // cpu store/load request
   typedef struct packed {
      logic        store_req;
      logic        load_req;
      logic [12:0] pc;
      logic [12:0] z_addr;
   } cpu_req_s;

endpackage : flash_guard_pkg

// >>> logic/flash_selfprog_section_guard.sv
`timescale 1ns/100ps
`include "flash_guard_regs.svh"

module flash_selfprog_section_guard
   import flash_guard_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic                     rst_b_i,
   input  wire logic                     clk_en_i,
   input  wire logic [1:0]               boot_size_fuses_i,
   input  wire logic                     vectors_in_boot_i,
   input  wire logic                     general_lock_mode_i,
   input  wire logic                     chip_erase_i,
   input  wire lock_bits_s               lock_prog_i,
   input  wire logic                     lock_prog_we_i,
   input  wire logic                     ctrl_we_i,
   input  wire logic [7:0]               ctrl_wdata_i,
   input  wire cpu_req_s                 cpu_req_i,
   output logic                          prog_start_o,
   output logic                          prog_erase_o,
   output logic [`FG_PAGE_W-1:0]         prog_page_o,
   output logic                          cpu_stall_o,
   output logic                          concurrent_blocked_o,
   output logic                          concurrent_section_busy_flag_o,
   output logic                          load_allow_o,
   output logic                          store_refused_o,
   output logic                          irq_mask_o,
   output lock_bits_s                    lock_bits_o,
   output logic                          self_program_enable_bit_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   guard_state_e              state_q, state_d;
   prog_op_e                  op_q, op_d;
   logic [2:0]                arm_cnt_q, arm_cnt_d;
   logic [`FG_CNT_W-1:0]      prog_cnt_q, prog_cnt_d;
   logic [`FG_PAGE_W-1:0]     page_q;
   logic                      page_halt_q;
   logic                      busy_q, busy_d;
   logic                      reen_q, reen_d;
   lock_bits_s                lock_q;

   // ----------------------------------------------------------------
   // section decode
   // ----------------------------------------------------------------
   logic [`FG_ADDR_W-1:0] boot_base;
   assign boot_base = (boot_size_fuses_i == 2'h0) ? `FG_BOOT_BASE_0 :
                      (boot_size_fuses_i == 2'h1) ? `FG_BOOT_BASE_1 :
                      (boot_size_fuses_i == 2'h2) ? `FG_BOOT_BASE_2 :
                                                    `FG_BOOT_BASE_3;

   wire pc_in_boot  = cpu_req_i.pc >= boot_base;
   wire z_in_boot   = cpu_req_i.z_addr >= boot_base;
   wire [`FG_PAGE_W-1:0] z_page = cpu_req_i.z_addr[`FG_PAGE_MSB:`FG_PAGE_LSB];
   wire z_in_halt   = cpu_req_i.z_addr >= `FG_HALT_BASE;

   // ----------------------------------------------------------------
   // access decisions
   // ----------------------------------------------------------------
   wire cmd_erase = (ctrl_wdata_i & `FG_CMD_MASK) == `FG_CMD_ERASE;
   wire cmd_write = (ctrl_wdata_i & `FG_CMD_MASK) == `FG_CMD_WRITE;
   wire cmd_reen  = (ctrl_wdata_i & `FG_CMD_MASK) == `FG_CMD_REEN;

   // each pair guards its own section; general lock unused
   wire wr_locked = z_in_boot ? ~lock_q.boot_write_lock_bit
                              : ~lock_q.application_write_lock_bit;
   wire store_ok  = cpu_req_i.store_req & (state_q == ST_ARMED) & pc_in_boot & ~wr_locked;
   wire store_bad = cpu_req_i.store_req & (state_q == ST_ARMED) & ~store_ok;

   wire rd_locked = (pc_in_boot & ~z_in_boot & ~lock_q.application_read_lock_bit) |
                    (~pc_in_boot & z_in_boot & ~lock_q.boot_read_lock_bit);
   wire z_in_conc = ~z_in_halt;
   assign load_allow_o = cpu_req_i.load_req & ~rd_locked & ~(busy_q & z_in_conc)
                         & ~cpu_stall_o;

   assign irq_mask_o = (vectors_in_boot_i & ~pc_in_boot & ~lock_q.application_read_lock_bit) |
                       (~vectors_in_boot_i & pc_in_boot & ~lock_q.boot_read_lock_bit);

   // stall for halting page; concurrent page runs
   assign cpu_stall_o = (state_q == ST_PROG) & page_halt_q;
   assign concurrent_blocked_o            = busy_q;
   assign concurrent_section_busy_flag_o  = busy_q;
   assign self_program_enable_bit_o       = state_q != ST_IDLE;
   assign lock_bits_o                     = lock_q;

   // ----------------------------------------------------------------
   // sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d    = state_q;
      op_d       = op_q;
      arm_cnt_d  = arm_cnt_q;
      prog_cnt_d = prog_cnt_q;
      busy_d     = busy_q;
      reen_d     = reen_q;
      case (state_q)
         ST_IDLE: begin
            if (ctrl_we_i && (cmd_erase || cmd_write)) begin
               state_d   = ST_ARMED;
               op_d      = cmd_erase ? OP_ERASE : OP_WRITE;
               arm_cnt_d = `FG_ARM_CYCLES;
            end
         end
         ST_ARMED: begin
            if (store_ok) begin
               state_d    = ST_PROG;
               prog_cnt_d = `FG_CNT_W'(`FG_PROG_CYCLES - 1);
               busy_d     = 1'b1;
            end else if (store_bad || arm_cnt_q == 3'h1) begin
               state_d = ST_IDLE;
               op_d    = OP_NONE;
            end else begin
               arm_cnt_d = arm_cnt_q - 3'h1;
            end
         end
         ST_PROG: begin
            if (prog_cnt_q == '0) begin
               state_d = ST_IDLE;
               op_d    = OP_NONE;
            end else begin
               prog_cnt_d = prog_cnt_q - `FG_CNT_W'(1);
            end
         end
         default: begin
            state_d = ST_IDLE;
            op_d    = OP_NONE;
         end
      endcase
      // re-enable held until programming ends; sticky otherwise
      if (ctrl_we_i && cmd_reen) begin
         reen_d = 1'b1;
      end
      if (reen_d && state_d != ST_PROG && state_q != ST_PROG) begin
         busy_d = 1'b0;
         reen_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sequencer registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q    <= ST_IDLE;
         op_q       <= OP_NONE;
         arm_cnt_q  <= '0;
         prog_cnt_q <= '0;
         busy_q     <= 1'b0;
         reen_q     <= 1'b0;
      end else if (clk_en_i) begin
         state_q    <= state_d;
         op_q       <= op_d;
         arm_cnt_q  <= arm_cnt_d;
         prog_cnt_q <= prog_cnt_d;
         busy_q     <= busy_d;
         reen_q     <= reen_d;
      end
   end

   // target page latch and start pulse
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         page_q          <= '0;
         page_halt_q     <= 1'b0;
         prog_start_o    <= 1'b0;
         prog_erase_o    <= 1'b0;
         store_refused_o <= 1'b0;
      end else if (clk_en_i) begin
         prog_start_o    <= store_ok;
         store_refused_o <= store_bad;
         if (store_ok) begin
            page_q       <= z_page;
            page_halt_q  <= z_in_halt;
            prog_erase_o <= op_q == OP_ERASE;
         end
      end
   end
   assign prog_page_o = page_q;

   // ----------------------------------------------------------------
   // lock bits, program-only until chip erase sets them back to one
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_q <= '1;
      end else if (clk_en_i) begin
         if (chip_erase_i) begin
            lock_q <= '1;
         end else if (lock_prog_we_i) begin
            lock_q <= lock_q & lock_prog_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // ----------------------------------------------------------------
   // store gating checks
   // ----------------------------------------------------------------
   // application store ignored
   AST_APP_STORE_IGNORED: assert property (
      cpu_req_i.store_req && !pc_in_boot |-> !store_ok)
      else $error("store from application accepted");

   AST_BOOT_STORE_OK: assert property (
      clk_en_i && state_q == ST_ARMED && cpu_req_i.store_req && pc_in_boot && !wr_locked
      |=> prog_start_o && busy_q)
      else $error("boot store not started");

   AST_BOOT_IN_HALT: assert property (
      boot_base >= `FG_HALT_BASE)
      else $error("boot section outside halting section");

   AST_WR_LOCK: assert property (
      cpu_req_i.store_req && wr_locked |-> !store_ok)
      else $error("locked store accepted");

   AST_BOOT_WR_LOCK: assert property (
      cpu_req_i.store_req && z_in_boot && !lock_q.boot_write_lock_bit |-> !store_ok)
      else $error("store into locked boot section accepted");

   AST_PAGE_LATCH: assert property (
      clk_en_i && store_ok |=> prog_page_o == $past(z_page))
      else $error("latched page differs from Z page");

   AST_ARM_LAPSE: assert property (
      clk_en_i && state_q == ST_IDLE && ctrl_we_i && cmd_erase ##1
      (clk_en_i && !cpu_req_i.store_req)[*4] |=> state_q == ST_IDLE)
      else $error("command did not lapse");

   AST_REFUSED_QUIET: assert property (
      clk_en_i && store_bad && !busy_q |=> !busy_q && !prog_start_o && !cpu_stall_o)
      else $error("refused store had effect");

   // ----------------------------------------------------------------
   // stall, busy and read checks
   // ----------------------------------------------------------------
   // halting page stalls
   AST_HALT_STALL: assert property (
      clk_en_i && store_ok && z_in_halt |=> cpu_stall_o)
      else $error("no stall for halting page");

   AST_HALT_NO_READ: assert property (
      state_q == ST_PROG && page_halt_q |-> !load_allow_o)
      else $error("read allowed while cpu halted");

   AST_CONC_NO_STALL: assert property (
      clk_en_i && store_ok && !z_in_halt |=> !cpu_stall_o && prog_start_o)
      else $error("stall for concurrent page");

   AST_BUSY_BLOCK: assert property (
      state_q == ST_PROG && z_in_conc |-> !load_allow_o)
      else $error("concurrent read during programming");

   AST_FLAG_IN_PROG: assert property (
      state_q == ST_PROG |-> concurrent_section_busy_flag_o)
      else $error("busy flag low while programming");

   AST_BUSY_STICKY: assert property (
      clk_en_i && busy_q && !(ctrl_we_i && cmd_reen) && !reen_q |=> busy_q)
      else $error("busy flag dropped without re-enable");

   AST_REEN_CLEARS: assert property (
      clk_en_i && busy_q && reen_q && state_q == ST_IDLE |=> !busy_q)
      else $error("re-enable did not clear busy flag");

   // ----------------------------------------------------------------
   // lock bit checks
   // ----------------------------------------------------------------
   // locks only program
   AST_LOCK_ONE_WAY: assert property (
      clk_en_i && !chip_erase_i |=> (lock_q & ~$past(lock_q)) == '0)
      else $error("lock bit returned to one");

   AST_RD_LOCK: assert property (
      cpu_req_i.load_req && rd_locked |-> !load_allow_o)
      else $error("locked load allowed");

   AST_BOOT_RD_LOCK: assert property (
      cpu_req_i.load_req && !pc_in_boot && z_in_boot && !lock_q.boot_read_lock_bit
      |-> !load_allow_o)
      else $error("load from locked boot section allowed");

   AST_APP_IRQ_MASK: assert property (
      vectors_in_boot_i && !pc_in_boot && !lock_q.application_read_lock_bit |-> irq_mask_o)
      else $error("interrupts open in application");

   AST_BOOT_IRQ_MASK: assert property (
      !vectors_in_boot_i && pc_in_boot && !lock_q.boot_read_lock_bit |-> irq_mask_o)
      else $error("interrupts open in boot section");

   // ----------------------------------------------------------------
   // scenario coverage
   // ----------------------------------------------------------------
   COV_LAPSE:      cover property (state_q == ST_ARMED && arm_cnt_q == 3'h1 && !store_ok);
   COV_ERASE_HALT: cover property (prog_start_o && prog_erase_o && page_halt_q);
   COV_WRITE_CONC: cover property (prog_start_o && !prog_erase_o && !page_halt_q);
   COV_REFUSED:    cover property (store_refused_o);
   COV_REEN:       cover property (busy_q ##1 !busy_q);

endmodule : flash_selfprog_section_guard

// >>> verif/cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model
   import flash_guard_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic stall_i,
   output cpu_req_s  req_o
);
   // ----------------------------------------------------------------
   // cpu side of store and load requests
   // ----------------------------------------------------------------
   // no interrupts taken
   // the core model never fetches a vector, so none can hit a blocked section
   initial req_o = '0;

   // store follows arming
   // called after the control write and any gap cycles, held across one edge
   task automatic store(input logic [12:0] pc, input logic [12:0] z);
      while (stall_i === 1'b1) @(negedge clk_i);
      req_o.store_req = 1'b1;
      req_o.load_req  = 1'b0;
      req_o.pc        = pc;
      req_o.z_addr    = z;
      @(negedge clk_i);
      req_o.store_req = 1'b0;
   endtask : store

   // no stall wait before reading
   // load lines held until the next call changes them
   task automatic load(input logic [12:0] pc, input logic [12:0] z);
      req_o.load_req = 1'b1;
      req_o.pc       = pc;
      req_o.z_addr   = z;
   endtask : load
endmodule : cpu_core_model

// >>> verif/flash_selfprog_section_guard_bench.sv
`timescale 1ns/100ps
`include "flash_guard_regs.svh"
module flash_selfprog_section_guard_bench
   import flash_guard_pkg::*;
;
   // ----------------------------------------------------------------
   // clock, reset, dut and cpu model
   // ----------------------------------------------------------------
   logic clk_i = 0, rst_b_i = 0, vib = 0, glm = 1, cer = 0, lwe = 0, cwe = 0;
   logic [1:0] fuse = 2'h3;
   logic [7:0] cwd = 8'h00;
   lock_bits_s lprog = 4'hf;
   cpu_req_s req;
   logic start, ers, stall, blk, busy, lda, refu, irqm, spe;
   logic [7:0] page;
   lock_bits_s lk;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   logic [12:0] base [4] = '{`FG_BOOT_BASE_0, `FG_BOOT_BASE_1, `FG_BOOT_BASE_2,
                             `FG_BOOT_BASE_3};
   always #10 clk_i = ~clk_i;
   cpu_core_model u_cpu (.clk_i(clk_i), .stall_i(stall), .req_o(req));
   flash_selfprog_section_guard u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
      .boot_size_fuses_i(fuse), .vectors_in_boot_i(vib), .general_lock_mode_i(glm),
      .chip_erase_i(cer), .lock_prog_i(lprog), .lock_prog_we_i(lwe), .ctrl_we_i(cwe),
      .ctrl_wdata_i(cwd), .cpu_req_i(req), .prog_start_o(start), .prog_erase_o(ers),
      .prog_page_o(page), .cpu_stall_o(stall), .concurrent_blocked_o(blk),
      .concurrent_section_busy_flag_o(busy), .load_allow_o(lda), .store_refused_o(refu),
      .irq_mask_o(irqm), .lock_bits_o(lk), .self_program_enable_bit_o(spe));

   task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task reset;
      rst_b_i = 0;
      repeat (20) @(negedge clk_i);
      rst_b_i = 1;
      @(negedge clk_i);
   endtask : reset
   task arm_store(input logic [7:0] cmd, input logic [12:0] pc, input logic [12:0] z,
                  input int gap);
      cwe = 1;
      cwd = cmd;
      @(negedge clk_i);
      cwe = 0;
      repeat (gap) @(negedge clk_i);
      u_cpu.store(pc, z);
   endtask : arm_store
   task set_locks(input logic [3:0] v);
      lprog = v;
      lwe   = 1;
      @(negedge clk_i);
      lwe   = 0;
   endtask : set_locks
   task load_chk(input string nm, input logic [12:0] pc, input logic [12:0] z,
                 input logic al, input logic im);
      u_cpu.load(pc, z);
      #1;
      check({nm, " load"}, lda, al);
      check({nm, " irq"}, irqm, im);
      @(negedge clk_i);
   endtask : load_chk

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      check("locks", lk, 4'hf);
      check("busy", {busy, stall, start, refu}, 4'h0);
      $display("reset values done");
   endtask : t_reset
   task t_app_store;
      arm_store(`FG_CMD_ERASE, 13'h0100, 13'h0200, 0);
      check("refused", {refu, start, busy, stall}, 4'h8);
      check("after", {busy, blk, stall}, 3'h0);
      $display("application store done");
   endtask : t_app_store
   task t_lapse;
      cwe = 1;
      cwd = `FG_CMD_WRITE;
      @(negedge clk_i);
      cwe = 0;
      check("armed", spe, 1'b1);
      repeat (4) @(negedge clk_i);
      u_cpu.store(13'h1f80, 13'h0040);
      check("lapsed", {start, refu, busy}, 3'h0);
      $display("arm lapse done");
   endtask : t_lapse
   task t_write_locks;
      set_locks(4'he);
      set_locks(4'hf);
      check("sticky", lk, 4'he);
      arm_store(`FG_CMD_WRITE, 13'h1f80, 13'h0040, 0);
      check("app wlock", {refu, start, busy}, 3'h4);
      arm_store(`FG_CMD_WRITE, 13'h1f80, 13'h1f90, 3);
      check("boot open", {refu, start}, 2'h1);
      reset();
      set_locks(4'hb);
      arm_store(`FG_CMD_ERASE, 13'h1f80, 13'h1fa0, 0);
      check("boot wlock", {refu, start, stall}, 3'h4);
      cer = 1;
      @(negedge clk_i);
      cer = 0;
      @(negedge clk_i);
      check("erased", lk, 4'hf);
      $display("write locks done");
   endtask : t_write_locks
   task t_read_locks;
      vib = 1;
      set_locks(4'hd);
      load_chk("boot to app", 13'h1f80, 13'h0100, 0, 0);
      load_chk("app to app", 13'h0100, 13'h0200, 1, 1);
      load_chk("app to boot", 13'h0100, 13'h1f90, 1, 1);
      vib = 0;
      set_locks(4'h5);
      for (int f = 0; f < 4; f++) begin
         fuse = f[1:0];
         check("inside halt", base[f] >= `FG_HALT_BASE, 1'b1);
         load_chk("below base", base[f] - 13'h1, base[f], 0, 0);
         load_chk("at base", base[f], base[f] - 13'h1, 0, 1);
      end
      fuse = 2'h3;
      cer  = 1;
      @(negedge clk_i);
      cer  = 0;
      $display("read locks done");
   endtask : t_read_locks
   task t_concurrent;
      reset();
      arm_store(`FG_CMD_WRITE, 13'h1f80, 13'h0040, 0);
      check("start", {start, ers, refu, stall}, 4'h8);
      check("page", page, 8'h02);
      check("busy", {busy, blk, spe}, 3'h7);
      load_chk("blocked", 13'h1f80, 13'h0100, 0, 0);
      load_chk("halt side", 13'h1f80, 13'h1c40, 1, 0);
      cwe = 1;
      cwd = `FG_CMD_REEN;
      @(negedge clk_i);
      cwe = 0;
      repeat (3) @(negedge clk_i);
      check("busy held", {busy, blk}, 2'h3);
      $display("concurrent page done");
   endtask : t_concurrent
   task t_halting;
      reset();
      arm_store(`FG_CMD_ERASE, 13'h1f80, 13'h1f80, 0);
      check("start", {start, ers, stall}, 3'h7);
      check("page", page, 8'hfc);
      load_chk("none", 13'h1f80, 13'h1f90, 0, 0);
      repeat (1000) @(negedge clk_i);
      check("still", {stall, busy}, 2'h3);
      reset();
      $display("halting page done");
   endtask : t_halting

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      reset();
      t_reset();
      t_app_store();
      t_lapse();
      t_write_locks();
      t_read_locks();
      t_concurrent();
      t_halting();
      conclude();
   end
endmodule : flash_selfprog_section_guard_bench
